// ==== hdl/i2sw_cdc_word.sv ====
`timescale 1ns/10ps
// word crossing by toggle; source must hold the word stable between toggles
module i2sw_cdc_word #(
  parameter int W = 4
) (
  input wire logic dst_clk,
  input wire logic reset_n,
  input wire logic src_toggle,
  input wire logic [W-1:0] src_word,
  output logic [W-1:0] dst_word,
  output logic dst_strobe
);
  typedef struct packed {
    logic seen;
    logic [W-1:0] word;
    logic strobe;
  } i2sw_cdc_st_t;

  i2sw_cdc_st_t s;
  i2sw_cdc_st_t next_s;
  logic tgl_s;

  i2sw_sync #(.W(1), .RST_VAL(1'b0)) u_tgl_sync (
    .clk(dst_clk),
    .reset_n(reset_n),
    .d(src_toggle),
    .q(tgl_s)
  );

  always_comb
  begin
    next_s = s;
    next_s.seen = tgl_s;
    next_s.strobe = tgl_s ^ s.seen;
    // word settled long before the toggle arrives two flops later
    if (tgl_s ^ s.seen)
    begin
      next_s.word = src_word;
    end
  end

  always_ff @(posedge dst_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      s <= '0;
    end
    else
    begin
      s <= next_s;
    end
  end

  assign dst_word = s.word;
  assign dst_strobe = s.strobe;
endmodule : i2sw_cdc_word

// ==== hdl/i2sw_sync.sv ====
`timescale 1ns/10ps
module i2sw_sync #(
  parameter int W = 1,
  parameter logic [W-1:0] RST_VAL = '0
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  typedef struct packed {
    logic [W-1:0] meta;
    logic [W-1:0] stable;
  } i2sw_sync_st_t;

  i2sw_sync_st_t s;
  i2sw_sync_st_t next_s;

  always_comb
  begin
    next_s.meta = d;
    next_s.stable = s.meta;
  end

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      s <= {RST_VAL, RST_VAL};
    end
    else
    begin
      s <= next_s;
    end
  end

  assign q = s.stable;
endmodule : i2sw_sync

// ==== hdl/i2sw_top.sv ====
// Operation
// - upstream pair connects to any combination of four channels
// - interrupt output is the AND of the four channel interrupt inputs
// - all channel interrupt inputs and the interrupt output are active low
// - reset pin low idles bus state machine and disconnects every channel
// - after power-up all channels stay off until a selection is written
// - two strapped address inputs form the variable part of target address
// - fixed upper address part is a variant parameter; all else identical
// - works from static bus clock up to fast-mode rate, no faster
`timescale 1ns/10ps
module i2sw_top #(
  parameter logic [4:0] ADDR_FIXED = i2sw_pkg::ADDR_FIXED_DEFAULT
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic link_clk,
  input wire logic upstream_clock_line,
  input wire logic upstream_data_in,
  output logic upstream_data_out,
  output logic upstream_data_oe,
  input wire logic addr_strap_bit0,
  input wire logic addr_strap_bit1,
  input wire logic chan0_irq_in_n,
  input wire logic chan1_irq_in_n,
  input wire logic chan2_irq_in_n,
  input wire logic chan3_irq_in_n,
  output logic irq_out_n,
  output logic [3:0] chan_connect,
  output logic [7:0] ctrl_value
);
  i2sw_pkg::i2sw_link_t ls;
  i2sw_pkg::i2sw_link_t next_ls;
  i2sw_pkg::i2sw_core_t cs;
  i2sw_pkg::i2sw_core_t next_cs;
  logic scl_s;
  logic sda_s;
  logic [1:0] strap_s;
  logic [3:0] irq_s;
  logic [3:0] xfer_word;
  logic xfer_strobe;
  logic scl_rise;
  logic scl_fall;
  logic start_det;
  logic stop_det;
  logic addr_hit;

  function automatic logic addr_match(
    input logic [7:0] addr_byte,
    input logic [4:0] fixed,
    input logic [1:0] strap
  );
    addr_match = addr_byte[7:1] == {fixed, strap};
  endfunction : addr_match

  // bus sampled on the fast link clock: any rate from static up to
  // fast mode is seen with many samples per phase
  i2sw_sync #(.W(2), .RST_VAL(2'b11)) u_bus_sync (
    .clk(link_clk),
    .reset_n(reset_n),
    .d({upstream_clock_line, upstream_data_in}),
    .q({scl_s, sda_s})
  );
  i2sw_sync #(.W(2), .RST_VAL(2'b00)) u_strap_sync (
    .clk(link_clk),
    .reset_n(reset_n),
    .d({addr_strap_bit1, addr_strap_bit0}),
    .q(strap_s)
  );
  i2sw_sync #(.W(4), .RST_VAL(4'hF)) u_irq_sync (
    .clk(clk),
    .reset_n(reset_n),
    .d({chan3_irq_in_n, chan2_irq_in_n, chan1_irq_in_n, chan0_irq_in_n}),
    .q(irq_s)
  );
  i2sw_cdc_word #(.W(i2sw_pkg::CHAN_N)) u_ctrl_cdc (
    .dst_clk(clk),
    .reset_n(reset_n),
    .src_toggle(ls.tgl),
    .src_word(ls.ctrl[i2sw_pkg::CTRL_CHAN_LSB +: i2sw_pkg::CHAN_N]),
    .dst_word(xfer_word),
    .dst_strobe(xfer_strobe)
  );

  assign scl_rise = scl_s & ~ls.scl_d;
  assign scl_fall = ~scl_s & ls.scl_d;
  assign start_det = scl_s & ls.scl_d & ls.sda_d & ~sda_s;
  assign stop_det = scl_s & ls.scl_d & ~ls.sda_d & sda_s;
  assign addr_hit = addr_match(ls.shreg, ADDR_FIXED, strap_s);

  always_comb
  begin
    next_ls = ls;
    next_ls.scl_d = scl_s;
    next_ls.sda_d = sda_s;
    next_ls.sda_lvl = 1'b0;
    case (ls.state)
      i2sw_pkg::I2SW_IDLE, i2sw_pkg::I2SW_IGNORE:
      begin
        next_ls.sda_oe = 1'b0;
      end
      i2sw_pkg::I2SW_ADDR:
      begin
        if (scl_rise)
        begin
          next_ls.shreg = {ls.shreg[6:0], sda_s};
          next_ls.cnt = ls.cnt + 4'h1;
        end
        else if (scl_fall && ls.cnt == i2sw_pkg::BYTE_BITS)
        begin
          if (addr_hit)
          begin
            next_ls.state = i2sw_pkg::I2SW_ADDR_ACK;
            next_ls.sda_oe = 1'b1;
            next_ls.rw = ls.shreg[i2sw_pkg::ADDR_RW_BIT];
          end
          else
          begin
            next_ls.state = i2sw_pkg::I2SW_IGNORE;
          end
        end
      end
      i2sw_pkg::I2SW_ADDR_ACK:
      begin
        if (scl_fall)
        begin
          next_ls.cnt = 4'h0;
          if (ls.rw)
          begin
            next_ls.shreg = ls.ctrl;
            next_ls.sda_oe = ~ls.ctrl[7];
            next_ls.state = i2sw_pkg::I2SW_RD_DATA;
          end
          else
          begin
            next_ls.sda_oe = 1'b0;
            next_ls.state = i2sw_pkg::I2SW_WR_DATA;
          end
        end
      end
      i2sw_pkg::I2SW_WR_DATA:
      begin
        if (scl_rise)
        begin
          next_ls.shreg = {ls.shreg[6:0], sda_s};
          next_ls.cnt = ls.cnt + 4'h1;
        end
        else if (scl_fall && ls.cnt == i2sw_pkg::BYTE_BITS)
        begin
          // held until stop so channels never switch mid-transaction
          next_ls.pend = ls.shreg;
          next_ls.pend_v = 1'b1;
          next_ls.sda_oe = 1'b1;
          next_ls.state = i2sw_pkg::I2SW_WR_ACK;
        end
      end
      i2sw_pkg::I2SW_WR_ACK:
      begin
        // later bytes are left unacknowledged
        if (scl_fall)
        begin
          next_ls.sda_oe = 1'b0;
          next_ls.state = i2sw_pkg::I2SW_IGNORE;
        end
      end
      i2sw_pkg::I2SW_RD_DATA:
      begin
        if (scl_fall)
        begin
          if (ls.cnt == i2sw_pkg::LAST_BIT)
          begin
            next_ls.sda_oe = 1'b0;
            next_ls.state = i2sw_pkg::I2SW_RD_ACK;
          end
          else
          begin
            next_ls.shreg = {ls.shreg[6:0], 1'b0};
            next_ls.cnt = ls.cnt + 4'h1;
            next_ls.sda_oe = ~ls.shreg[6];
          end
        end
      end
      i2sw_pkg::I2SW_RD_ACK:
      begin
        if (scl_rise)
        begin
          next_ls.nack = sda_s;
        end
        else if (scl_fall)
        begin
          if (ls.nack)
          begin
            next_ls.state = i2sw_pkg::I2SW_IGNORE;
          end
          else
          begin
            next_ls.cnt = 4'h0;
            next_ls.shreg = ls.ctrl;
            next_ls.sda_oe = ~ls.ctrl[7];
            next_ls.state = i2sw_pkg::I2SW_RD_DATA;
          end
        end
      end
      default:
      begin
        next_ls.state = i2sw_pkg::I2SW_IDLE;
        next_ls.sda_oe = 1'b0;
      end
    endcase
    if (start_det)
    begin
      next_ls.state = i2sw_pkg::I2SW_ADDR;
      next_ls.cnt = 4'h0;
      next_ls.sda_oe = 1'b0;
    end
    if (stop_det)
    begin
      next_ls.state = i2sw_pkg::I2SW_IDLE;
      next_ls.sda_oe = 1'b0;
      if (ls.pend_v)
      begin
        next_ls.ctrl = ls.pend;
        next_ls.pend_v = 1'b0;
        next_ls.tgl = ~ls.tgl;
      end
    end
  end

  always_ff @(posedge link_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      ls <= '0;
      ls.state <= i2sw_pkg::I2SW_IDLE;
      ls.ctrl <= i2sw_pkg::CTRL_RESET;
      ls.scl_d <= 1'b1;
      ls.sda_d <= 1'b1;
    end
    else
    begin
      ls <= next_ls;
    end
  end

  always_comb
  begin
    next_cs = cs;
    next_cs.irq_n = &irq_s;
    if (xfer_strobe)
    begin
      next_cs.chan_en = xfer_word;
    end
  end

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      cs.chan_en <= 4'h0;
      cs.irq_n <= 1'b1;
    end
    else
    begin
      cs <= next_cs;
    end
  end

  assign chan_connect = cs.chan_en;
  assign irq_out_n = cs.irq_n;
  assign upstream_data_out = ls.sda_lvl;
  assign upstream_data_oe = ls.sda_oe;
  assign ctrl_value = ls.ctrl;

  property p_chan_follow;
    @(posedge clk) disable iff (!reset_n)
    xfer_strobe |=> chan_connect == $past(xfer_word);
  endproperty
  a_chan_follow: assert property (p_chan_follow)
    else $error("channel enables did not follow control word");
  property p_irq_any_low;
    @(posedge clk) disable iff (!reset_n)
    (irq_s != 4'hF) |=> !irq_out_n;
  endproperty
  a_irq_any_low: assert property (p_irq_any_low)
    else $error("interrupt output not low while an input is low");
  property p_irq_all_high;
    @(posedge clk) disable iff (!reset_n)
    (irq_s == 4'hF) [*2] |-> irq_out_n;
  endproperty
  a_irq_all_high: assert property (p_irq_all_high)
    else $error("interrupt output low with all inputs high");
  property p_reset_clear;
    @(posedge clk) !reset_n |-> chan_connect == 4'h0;
  endproperty
  a_reset_clear: assert property (p_reset_clear)
    else $error("channel connected during reset");
  property p_change_cause;
    @(posedge clk) disable iff (!reset_n)
    $changed(chan_connect) |-> $past(xfer_strobe);
  endproperty
  a_change_cause: assert property (p_change_cause)
    else $error("channels changed without a written selection");
  sequence s_addr_done;
    ls.state == i2sw_pkg::I2SW_ADDR && scl_fall && !start_det && !stop_det
      && ls.cnt == i2sw_pkg::BYTE_BITS;
  endsequence
  property p_addr_ack;
    @(posedge link_clk) disable iff (!reset_n)
    s_addr_done ##0 addr_hit |=>
      ls.state == i2sw_pkg::I2SW_ADDR_ACK && upstream_data_oe;
  endproperty
  a_addr_ack: assert property (p_addr_ack)
    else $error("matching address not acknowledged");
  property p_addr_miss;
    @(posedge link_clk) disable iff (!reset_n)
    s_addr_done ##0 (ls.shreg[7:3] != ADDR_FIXED) |=>
      ls.state == i2sw_pkg::I2SW_IGNORE && !upstream_data_oe;
  endproperty
  a_addr_miss: assert property (p_addr_miss)
    else $error("foreign fixed address acknowledged");
  property p_low_bits_only;
    @(posedge link_clk) disable iff (!reset_n)
    $changed(ls.tgl) |-> $past(ls.pend[3:0]) == ls.ctrl[3:0];
  endproperty
  a_low_bits_only: assert property (p_low_bits_only)
    else $error("committed channel bits differ from written byte");
  sequence s_write_held;
    ls.pend_v && !stop_det;
  endsequence
  property p_commit_at_stop;
    @(posedge link_clk) disable iff (!reset_n)
    s_write_held |=> $stable(ctrl_value);
  endproperty
  a_commit_at_stop: assert property (p_commit_at_stop)
    else $error("control changed before stop condition");
endmodule : i2sw_top

// ==== include/i2sw_pkg.sv ====
package i2sw_pkg;
  localparam int CHAN_N = 4;
  localparam int CTRL_W = 8;
  localparam int STRAP_W = 2;
  localparam int FIXED_W = 5;
  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam int CTRL_CHAN_LSB = 0;
  localparam int ADDR_RW_BIT = 0;
  localparam int ADDR_STRAP_LSB = 1;
  localparam int ADDR_FIXED_LSB = 3;
  localparam logic [4:0] ADDR_FIXED_DEFAULT = 5'h10;
  localparam logic [3:0] BYTE_BITS = 4'h8;
  localparam logic [3:0] LAST_BIT = 4'h7;
  localparam int FAST_MODE_MAX_HZ = 400_000;

  typedef enum logic [7:0] {
    I2SW_IDLE = 8'h01,
    I2SW_ADDR = 8'h02,
    I2SW_ADDR_ACK = 8'h04,
    I2SW_WR_DATA = 8'h08,
    I2SW_WR_ACK = 8'h10,
    I2SW_RD_DATA = 8'h20,
    I2SW_RD_ACK = 8'h40,
    I2SW_IGNORE = 8'h80
  } i2sw_state_t;

  typedef struct packed {
    i2sw_state_t state;
    logic [3:0] cnt;
    logic [7:0] shreg;
    logic rw;
    logic nack;
    logic [7:0] pend;
    logic pend_v;
    logic [7:0] ctrl;
    logic tgl;
    logic scl_d;
    logic sda_d;
    logic sda_lvl;
    logic sda_oe;
  } i2sw_link_t;

  typedef struct packed {
    logic [3:0] chan_en;
    logic irq_n;
  } i2sw_core_t;
endpackage : i2sw_pkg

// ==== tb/i2sw_tb_master.sv ====
`timescale 1ns/10ps
module i2sw_tb_master (
  input wire logic clk,
  input wire logic sda_lvl,
  output logic scl,
  output logic sda_pull
);
  initial
  begin
    scl = 1'b1;
    sda_pull = 1'b0;
  end
  // some 2.7 us a bit, safely under the fast-mode rate
  task hp;
    repeat (157) @(negedge clk);
  endtask : hp
  // data moves only while the clock is low, well after its fall
  task bit_io(input logic b, output logic r);
    repeat (20) @(negedge clk);
    sda_pull = !b;
    hp();
    scl = 1'b1;
    hp();
    r = sda_lvl;
    scl = 1'b0;
  endtask : bit_io
  task start;
    sda_pull = 1'b1;
    hp();
    scl = 1'b0;
  endtask : start
  task stop;
    repeat (20) @(negedge clk);
    sda_pull = 1'b1;
    hp();
    scl = 1'b1;
    hp();
    sda_pull = 1'b0;
    hp();
  endtask : stop
  task wr_byte(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--)
      bit_io(d[i], r);
    bit_io(1'b1, r);
    ack = !r;
  endtask : wr_byte
  // last high leaves the line released, a refusal ending the read
  task rd_byte(input logic last, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--)
      bit_io(1'b1, d[i]);
    bit_io(last, r);
  endtask : rd_byte
endmodule : i2sw_tb_master

// ==== tb/tb_top.sv ====
`timescale 1ns/10ps
module tb_top;
  localparam logic [4:0] FIX = 5'h13;
  logic clk = 1'b0;
  logic link_clk = 1'b0;
  logic reset_n = 1'b1;
  logic scl, pull, oe, dout, irq_n;
  logic [1:0] strap = 2'b10;
  logic [3:0] irq = 4'hf;
  logic [3:0] chan;
  logic [7:0] ctrl, cur = 8'h00;
  int num_errors = 0;
  int num_checks = 0;
  wire sda = !(pull | (oe & !dout));
  initial
  begin
    forever #4 clk = !clk;
  end
  initial
  begin
    #1.3;
    forever #3 link_clk = !link_clk;
  end
  i2sw_top #(.ADDR_FIXED(FIX)) u_dut (
    .clk(clk), .reset_n(reset_n), .link_clk(link_clk),
    .upstream_clock_line(scl), .upstream_data_in(sda),
    .upstream_data_out(dout), .upstream_data_oe(oe),
    .addr_strap_bit0(strap[0]), .addr_strap_bit1(strap[1]),
    .chan0_irq_in_n(irq[0]), .chan1_irq_in_n(irq[1]),
    .chan2_irq_in_n(irq[2]), .chan3_irq_in_n(irq[3]),
    .irq_out_n(irq_n), .chan_connect(chan), .ctrl_value(ctrl)
  );
  i2sw_tb_master u_mst (
    .clk(clk), .sda_lvl(sda), .scl(scl), .sda_pull(pull)
  );
  task stop_test;
    if (num_errors == 0 && num_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : stop_test
  task check(input string what, input logic [7:0] seen, input logic [7:0] e);
    num_checks++;
    if (seen !== e)
    begin
      num_errors++;
      $display("CHECK FAILED %s expected %h seen %h", what, e, seen);
    end
  endtask : check
  // bounded wait for the selection to cross into the system clock
  task wait_chan;
    int i;
    for (i = 0; i < 50 && chan !== cur[3:0]; i++)
      @(negedge clk);
    check("chan_connect", {4'h0, chan}, {4'h0, cur[3:0]});
    if (i == 50)
      stop_test();
  endtask : wait_chan
  task wr(input logic [1:0] s, input logic [7:0] d, input logic hit);
    logic ack;
    u_mst.start();
    u_mst.wr_byte({FIX, s, 1'b0}, ack);
    check("addr_ack", 8'(ack), 8'(hit));
    if (hit)
    begin
      u_mst.wr_byte(d, ack);
      check("data_ack", 8'(ack), 8'h01);
      check("ctrl_before_stop", ctrl, cur);
      cur = d;
    end
    u_mst.stop();
    check("ctrl_value", ctrl, cur);
    wait_chan();
  endtask : wr
  task t_reset;
    check("chan_rst", {4'h0, chan}, 8'h00);
    check("ctrl_rst", ctrl, 8'h00);
    check("oe_rst", 8'(oe), 8'h00);
    check("irq_rst", 8'(irq_n), 8'h01);
  endtask : t_reset
  task t_write;
    wr(strap, 8'hf5, 1'b1);
    wr(strap, 8'h0a, 1'b1);
    wr(strap, 8'h03, 1'b1);
  endtask : t_write
  task t_addr;
    logic ack;
    wr(~strap, 8'h0c, 1'b0);
    // right straps, foreign fixed part
    u_mst.start();
    u_mst.wr_byte({FIX ^ 5'h01, strap, 1'b0}, ack);
    check("fixed_miss_ack", 8'(ack), 8'h00);
    u_mst.stop();
    check("ctrl_after_miss", ctrl, cur);
    strap = 2'b01;
    repeat (4) @(negedge clk);
    wr(2'b01, 8'h0c, 1'b1);
  endtask : t_addr
  task t_read;
    logic ack;
    logic [7:0] d;
    u_mst.start();
    u_mst.wr_byte({FIX, strap, 1'b1}, ack);
    check("rd_addr_ack", 8'(ack), 8'h01);
    u_mst.rd_byte(1'b0, d);
    check("rd_first", d, cur);
    u_mst.rd_byte(1'b1, d);
    check("rd_second", d, cur);
    u_mst.stop();
  endtask : t_read
  task t_extra;
    logic ack;
    u_mst.start();
    u_mst.wr_byte({FIX, strap, 1'b0}, ack);
    u_mst.wr_byte(8'h06, ack);
    u_mst.wr_byte(8'h09, ack);
    check("extra_nack", 8'(ack), 8'h00);
    u_mst.stop();
    cur = 8'h06;
    check("ctrl_one_byte", ctrl, cur);
    wait_chan();
  endtask : t_extra
  task t_irq;
    for (int i = 0; i < 16; i++)
    begin
      irq = 4'(i);
      repeat (4) @(negedge clk);
      check("irq_out_n", 8'(irq_n), 8'(&irq));
    end
    irq = 4'hf;
  endtask : t_irq
  task t_rst;
    reset_n = 1'b0;
    repeat (2) @(negedge clk);
    check("chan_mid_rst", {4'h0, chan}, 8'h00);
    check("ctrl_mid_rst", ctrl, 8'h00);
    reset_n = 1'b1;
    cur = 8'h00;
    repeat (10) @(negedge clk);
    wr(strap, 8'h0f, 1'b1);
  endtask : t_rst
  initial
  begin
    // a real falling edge, so the async reset fires before the first clock
    #1;
    reset_n = 1'b0;
    repeat (10) @(negedge clk);
    reset_n = 1'b1;
    repeat (10) @(negedge clk);
    t_reset();
    t_write();
    t_addr();
    t_read();
    t_extra();
    t_irq();
    t_rst();
    stop_test();
  end
endmodule : tb_top
